/* File: common/stack_link_pkg.sv */
// Shared constants and types for the stack and subroutine linkage unit
package stack_link_pkg;

	localparam int unsigned DATA_W = 16;
	localparam int unsigned SEL_W  = 3;
	localparam int unsigned NUM_REGS = 8;

	localparam logic [SEL_W-1:0] HW_STACK_SEL = 3'h6;
	localparam logic [SEL_W-1:0] PC_SEL       = 3'h7;

	localparam logic [DATA_W-1:0] STEP_WORD  = 16'h0002;
	localparam logic [DATA_W-1:0] STEP_BYTE  = 16'h0001;
	localparam logic [DATA_W-1:0] EVEN_MASK  = 16'hfffe;
	localparam logic [DATA_W-1:0] REG_RESET  = 16'h0000;
	localparam logic [DATA_W-1:0] BYTE_MASK  = 16'h00ff;

	typedef enum logic [2:0] {
		OP_LOAD = 3'h0,
		OP_READ = 3'h1,
		OP_PUSH = 3'h2,
		OP_POP  = 3'h3,
		OP_CALL = 3'h4,
		OP_RET  = 3'h5
	} op_kind_t;

	typedef struct packed {
		op_kind_t            kind;
		logic [SEL_W-1:0]    sel;
		logic                is_byte;
		logic [DATA_W-1:0]   data;
	} op_t;

	typedef struct packed {
		logic [DATA_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                write;
		logic                is_byte;
	} mem_cmd_t;

endpackage

/* File: logic/general_reg_file.sv */
// Eight general registers with one write port and a registered read port
`timescale 1ns/1ns
`default_nettype none

module general_reg_file (
	input  wire logic                              core_clk,
	input  wire logic                              resetn,
	input  wire logic                              ce,
	input  wire logic [stack_link_pkg::SEL_W-1:0]  rd_sel,
	output var  logic [stack_link_pkg::DATA_W-1:0] rd_data_q,
	input  wire logic                              wr_en,
	input  wire logic [stack_link_pkg::SEL_W-1:0]  wr_sel,
	input  wire logic [stack_link_pkg::DATA_W-1:0] wr_data
);

	logic [stack_link_pkg::DATA_W-1:0] regs_q [stack_link_pkg::NUM_REGS];
	logic [stack_link_pkg::DATA_W-1:0] rd_data_d;

	genvar gi;
	generate
		for (gi = 0; gi < stack_link_pkg::NUM_REGS; gi++) begin : g_entry
			logic [stack_link_pkg::DATA_W-1:0] entry_d;
			always_comb begin
				entry_d = regs_q[gi];
				if (wr_en && (wr_sel == stack_link_pkg::SEL_W'(gi))) begin
					entry_d = wr_data;
				end
			end
			always_ff @(posedge core_clk) begin
				if (!resetn) begin
					regs_q[gi] <= stack_link_pkg::REG_RESET;
				end else if (ce) begin
					regs_q[gi] <= entry_d;
				end
			end
		end
	endgenerate

	always_comb begin
		rd_data_d = regs_q[rd_sel];
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rd_data_q <= stack_link_pkg::REG_RESET;
		end else if (ce) begin
			rd_data_q <= rd_data_d;
		end
	end

endmodule // general_reg_file

`default_nettype wire

/* File: logic/stack_linkage_unit.sv */
// Stack push/pop and subroutine call/return sequencer over the general registers
`timescale 1ns/1ns
`default_nettype none

module stack_linkage_unit (
	input  wire logic                              core_clk,
	input  wire logic                              resetn,
	input  wire logic                              ce,
	input  wire logic                              op_valid,
	input  wire stack_link_pkg::op_t               op_in,
	output var  logic                              op_ready_q,
	output var  logic                              done_q,
	output var  logic                              err_q,
	output var  logic [stack_link_pkg::DATA_W-1:0] result_q,
	output var  logic                              mem_valid_q,
	output var  stack_link_pkg::mem_cmd_t          mem_cmd_q,
	input  wire logic                              mem_ack,
	input  wire logic [stack_link_pkg::DATA_W-1:0] mem_rdata
);

	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_RDL  = 8'h02,
		S_RDS  = 8'h04,
		S_RDP  = 8'h08,
		S_MEM  = 8'h10,
		S_WB   = 8'h20,
		S_WB2  = 8'h40,
		S_DONE = 8'h80
	} state_t;

	state_t                            state_q, state_d;
	stack_link_pkg::op_t               op_q, op_d;
	logic [stack_link_pkg::DATA_W-1:0] link_q, link_d;
	logic [stack_link_pkg::DATA_W-1:0] sp_q, sp_d;
	logic [stack_link_pkg::DATA_W-1:0] pc_q, pc_d;
	logic [stack_link_pkg::DATA_W-1:0] result_d;
	logic                              ready_d, done_d, err_d, mem_valid_d;
	stack_link_pkg::mem_cmd_t          mem_cmd_d;

	logic [stack_link_pkg::SEL_W-1:0]  rd_sel;
	logic [stack_link_pkg::DATA_W-1:0] rd_data;
	logic                              wr_en;
	logic [stack_link_pkg::SEL_W-1:0]  wr_sel;
	logic [stack_link_pkg::DATA_W-1:0] wr_data;
	logic [stack_link_pkg::DATA_W-1:0] wr_val;
	logic [stack_link_pkg::DATA_W-1:0] step;

	general_reg_file u_regs (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.ce        (ce),
		.rd_sel    (rd_sel),
		.rd_data_q (rd_data),
		.wr_en     (wr_en),
		.wr_sel    (wr_sel),
		.wr_data   (wr_data)
	);

	// Hardware stack pointer never takes an odd value
	always_comb begin
		wr_data = wr_val;
		if (wr_sel == stack_link_pkg::HW_STACK_SEL) begin
			wr_data = wr_val & stack_link_pkg::EVEN_MASK;
		end
	end

	// Step size per access width and pointer
	always_comb begin
		step = stack_link_pkg::STEP_WORD;
		if (op_q.is_byte && (op_q.sel != stack_link_pkg::HW_STACK_SEL)) begin
			step = stack_link_pkg::STEP_BYTE;
		end
	end

	always_comb begin
		state_d     = state_q;
		op_d        = op_q;
		link_d      = link_q;
		sp_d        = sp_q;
		pc_d        = pc_q;
		result_d    = result_q;
		ready_d     = op_ready_q;
		done_d      = 1'b0;
		err_d       = err_q;
		mem_valid_d = mem_valid_q;
		mem_cmd_d   = mem_cmd_q;
		rd_sel      = op_q.sel;
		wr_en       = 1'b0;
		wr_sel      = op_q.sel;
		wr_val      = op_q.data;
		unique case (state_q)
			S_IDLE: begin
				rd_sel = op_in.sel;
				if (op_valid && op_ready_q) begin
					op_d    = op_in;
					ready_d = 1'b0;
					err_d   = 1'b0;
					if (op_in.kind == stack_link_pkg::OP_LOAD) begin
						wr_en   = 1'b1;
						wr_sel  = op_in.sel;
						wr_val  = op_in.data;
						state_d = S_DONE;
					end else if ((op_in.kind == stack_link_pkg::OP_PUSH ||
							op_in.kind == stack_link_pkg::OP_POP) &&
							op_in.sel == stack_link_pkg::PC_SEL) begin
						err_d   = 1'b1;
						state_d = S_DONE;
					end else if (op_in.kind == stack_link_pkg::OP_CALL ||
							op_in.kind == stack_link_pkg::OP_RET) begin
						state_d = S_RDL;
					end else begin
						state_d = S_RDS;
					end
				end
			end
			S_RDL: begin
				link_d  = rd_data;
				rd_sel  = stack_link_pkg::HW_STACK_SEL;
				state_d = S_RDS;
			end
			S_RDS: begin
				sp_d   = rd_data;
				rd_sel = stack_link_pkg::PC_SEL;
				unique case (op_q.kind)
					stack_link_pkg::OP_READ: begin
						result_d = rd_data;
						state_d  = S_DONE;
					end
					stack_link_pkg::OP_PUSH: begin
						wr_en               = 1'b1;
						wr_val              = rd_data - step;
						mem_valid_d         = 1'b1;
						mem_cmd_d.addr      = rd_data - step;
						mem_cmd_d.wdata     = op_q.data;
						mem_cmd_d.write     = 1'b1;
						mem_cmd_d.is_byte   = op_q.is_byte;
						state_d             = S_MEM;
					end
					stack_link_pkg::OP_POP: begin
						mem_valid_d       = 1'b1;
						mem_cmd_d.addr    = rd_data;
						mem_cmd_d.write   = 1'b0;
						mem_cmd_d.is_byte = op_q.is_byte;
						state_d           = S_MEM;
					end
					stack_link_pkg::OP_RET: begin
						wr_en             = 1'b1;
						wr_sel            = stack_link_pkg::PC_SEL;
						wr_val            = link_q;
						mem_valid_d       = 1'b1;
						mem_cmd_d.addr    = rd_data;
						mem_cmd_d.write   = 1'b0;
						mem_cmd_d.is_byte = 1'b0;
						state_d           = S_MEM;
					end
					default: begin
						state_d = S_RDP;
					end
				endcase
			end
			S_RDP: begin
				pc_d              = rd_data;
				wr_en             = 1'b1;
				wr_sel            = stack_link_pkg::HW_STACK_SEL;
				wr_val            = sp_q - stack_link_pkg::STEP_WORD;
				mem_valid_d       = 1'b1;
				mem_cmd_d.addr    = (sp_q - stack_link_pkg::STEP_WORD) & stack_link_pkg::EVEN_MASK;
				mem_cmd_d.wdata   = link_q;
				mem_cmd_d.write   = 1'b1;
				mem_cmd_d.is_byte = 1'b0;
				state_d           = S_MEM;
			end
			S_MEM: begin
				if (mem_ack) begin
					mem_valid_d = 1'b0;
					result_d    = op_q.is_byte ? (mem_rdata & stack_link_pkg::BYTE_MASK) : mem_rdata;
					unique case (op_q.kind)
						stack_link_pkg::OP_PUSH: state_d = S_DONE;
						stack_link_pkg::OP_POP:  state_d = S_WB2;
						default:                 state_d = S_WB;
					endcase
				end
			end
			S_WB: begin
				// Linkage register naming the stack pointer is left to software
				wr_en   = 1'b1;
				wr_val  = (op_q.kind == stack_link_pkg::OP_CALL) ? pc_q : result_q;
				state_d = S_WB2;
			end
			S_WB2: begin
				wr_en = 1'b1;
				if (op_q.kind == stack_link_pkg::OP_CALL) begin
					wr_sel = stack_link_pkg::PC_SEL;
					wr_val = op_q.data;
				end else if (op_q.kind == stack_link_pkg::OP_RET) begin
					wr_sel = stack_link_pkg::HW_STACK_SEL;
					wr_val = sp_q + stack_link_pkg::STEP_WORD;
				end else begin
					wr_val = sp_q + step;
				end
				state_d = S_DONE;
			end
			S_DONE: begin
				done_d  = 1'b1;
				ready_d = 1'b1;
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q     <= S_IDLE;
			op_q        <= '0;
			link_q      <= stack_link_pkg::REG_RESET;
			sp_q        <= stack_link_pkg::REG_RESET;
			pc_q        <= stack_link_pkg::REG_RESET;
			result_q    <= stack_link_pkg::REG_RESET;
			op_ready_q  <= 1'b1;
			done_q      <= 1'b0;
			err_q       <= 1'b0;
			mem_valid_q <= 1'b0;
			mem_cmd_q   <= '0;
		end else if (ce) begin
			state_q     <= state_d;
			op_q        <= op_d;
			link_q      <= link_d;
			sp_q        <= sp_d;
			pc_q        <= pc_d;
			result_q    <= result_d;
			op_ready_q  <= ready_d;
			done_q      <= done_d;
			err_q       <= err_d;
			mem_valid_q <= mem_valid_d;
			mem_cmd_q   <= mem_cmd_d;
		end
	end

endmodule // stack_linkage_unit

`default_nettype wire

/* File: tb/stack_link_assertions.sv */
// Port checker for the stack linkage unit
`timescale 1ns/1ns
`default_nettype none
module stack_link_assertions (
	input wire logic                     core_clk,
	input wire logic                     resetn,
	input wire logic                     op_valid,
	input wire stack_link_pkg::op_t      op_in,
	input wire logic                     op_ready_q,
	input wire logic                     done_q,
	input wire logic                     err_q,
	input wire logic [15:0]              result_q,
	input wire logic                     mem_valid_q,
	input wire stack_link_pkg::mem_cmd_t mem_cmd_q,
	input wire logic                     mem_ack
);
	stack_link_pkg::op_t o_q;
	wire logic           acc = op_valid && op_ready_q;
	wire logic           rf  = acc && op_in.kind[2:1] == 2'h1 && op_in.sel == 3'h7;
	always_ff @(posedge core_clk) if (acc) o_q <= op_in;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	refuse_pc_a: assert property (rf |=> !mem_valid_q ##1 done_q && err_q)
		else $error("refused op not answered with error");
	push_write_a: assert property (mem_valid_q && o_q.kind == 3'h2 |-> mem_cmd_q.write)
		else $error("push without memory write");
	pop_read_a: assert property (mem_valid_q && o_q.kind inside {3'h3, 3'h5} |->
		!mem_cmd_q.write) else $error("pop or return wrote memory");
	call_push_a: assert property (mem_valid_q && o_q.kind == 3'h4 |->
		mem_cmd_q.write && !mem_cmd_q.is_byte) else $error("call push not a word write");
	hw_even_a: assert property (mem_valid_q && (o_q.kind[2] || o_q.sel == 3'h6) |->
		!mem_cmd_q.addr[0]) else $error("hardware stack address odd");
	cmd_hold_a: assert property (mem_valid_q && !mem_ack |=> mem_valid_q && $stable(mem_cmd_q))
		else $error("memory request changed before ack");
	ack_drop_a: assert property (mem_valid_q && mem_ack |=> !mem_valid_q)
		else $error("memory request held after ack");
	busy_a: assert property (acc |=> !op_ready_q until done_q)
		else $error("ready before done");
	done_in_a: assert property (acc |-> ##[2:40] done_q)
		else $error("operation never finished");
	byte_pop_a: assert property (done_q && o_q.kind == 3'h3 && o_q.is_byte && !err_q |->
		result_q[15:8] == 8'h00) else $error("byte pop upper half not zero");
	cover property (rf);
	cover property (acc && op_in.kind == 3'h4);
	cover property (mem_valid_q && !mem_ack ##1 mem_ack);
endmodule // stack_link_assertions
`default_nettype wire

/* File: tb/stack_mem_model.sv */
// Memory model answering the unit's stack requests
`timescale 1ns/1ns
`default_nettype none
module stack_mem_model (
	input  wire logic                     core_clk,
	input  wire logic                     mem_valid_q,
	input  wire stack_link_pkg::mem_cmd_t mem_cmd_q,
	output var  logic                     mem_ack,
	output var  logic [15:0]              mem_rdata
);
	logic [7:0]  m [logic [15:0]];
	logic [7:0]  lo, hi;
	logic [15:0] a;
	int          w = 0, n = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 16'h5a5a;
	end
	always @(posedge core_clk) begin
		#1;
		mem_ack = 1'b0;
		mem_rdata = ~mem_rdata;
		a = mem_cmd_q.addr;
		if (mem_valid_q && w > 0)
			w--;
		else if (mem_valid_q) begin
			mem_ack = 1'b1;
			w = n++ % 3;
			lo = m.exists(a) ? m[a] : 8'h00;
			hi = m.exists(a + 16'h1) ? m[a + 16'h1] : 8'h00;
			if (mem_cmd_q.write) m[a] = mem_cmd_q.wdata[7:0];
			if (mem_cmd_q.write && !mem_cmd_q.is_byte) m[a + 16'h1] = mem_cmd_q.wdata[15:8];
			mem_rdata = mem_cmd_q.is_byte ? {lo, lo} : {hi, lo};
		end
	end
endmodule // stack_mem_model
`default_nettype wire

/* File: tb/tb_stack_linkage_unit.sv */
// Randomised self-checking bench for the stack linkage unit
`timescale 1ns/1ns
`default_nettype none
module tb_stack_linkage_unit;
	logic                     core_clk, resetn, op_valid, op_ready_q, done_q, err_q;
	logic                     mem_valid_q, mem_ack;
	logic [15:0]              result_q, mem_rdata;
	stack_link_pkg::op_t      op_in;
	stack_link_pkg::mem_cmd_t mem_cmd_q;
	logic [15:0]              r [8];
	logic [7:0]               sm [logic [15:0]];
	logic [31:0]              rs = 32'hd77d;
	int                       mismatches = 0, n_checks = 0;
	stack_linkage_unit dut (.core_clk, .resetn, .ce(1'b1), .op_valid, .op_in, .op_ready_q,
		.done_q, .err_q, .result_q, .mem_valid_q, .mem_cmd_q, .mem_ack, .mem_rdata);
	stack_mem_model mem (.core_clk, .mem_valid_q, .mem_cmd_q, .mem_ack, .mem_rdata);
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [15:0] rd(logic [15:0] a, logic b);
		logic [7:0] lo, hi;
		lo = sm.exists(a) ? sm[a] : 8'h00;
		hi = sm.exists(a + 16'h1) ? sm[a + 16'h1] : 8'h00;
		return b ? {8'h00, lo} : {hi, lo};
	endfunction
	function automatic logic [15:0] st(logic [2:0] s, logic b);
		return b && s != stack_link_pkg::HW_STACK_SEL ?
			stack_link_pkg::STEP_BYTE : stack_link_pkg::STEP_WORD;
	endfunction
	task automatic wr(logic [15:0] a, logic b, logic [15:0] d);
		sm[a] = d[7:0];
		if (!b) sm[a + 16'h1] = d[15:8];
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h got %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Codes: 0 load, 1 read, 2 push, 3 pop, 4 call, 5 return
	task automatic op(int c, logic [2:0] s, logic b, logic [15:0] d);
		logic [15:0] a, v;
		logic        f;
		int          i;
		f = c inside {2, 3} && s == 3'h7;
		op_in = '{stack_link_pkg::op_kind_t'(c[2:0]), s, b, d};
		op_valid = 1'b1;
		@(posedge core_clk);
		#1 op_valid = 1'b0;
		for (i = 0; done_q !== 1'b1; i++) begin
			if (i > 60) begin
				mismatches++;
				finish_test();
			end
			@(posedge core_clk);
			#1;
		end
		a = r[s];
		if (c == 0) r[s] = s == 3'h6 ? d & stack_link_pkg::EVEN_MASK : d;
		if (c == 1) chk("read", a, result_q);
		if (c == 2 && !f) begin
			a = a - st(s, b);
			wr(a, b, d);
			r[s] = a;
		end
		if (c == 3 && !f) begin
			chk("pop", rd(a, b), result_q);
			r[s] = a + st(s, b);
		end
		if (c == 4) begin
			r[6] = r[6] - 16'h2;
			wr(r[6], 1'b0, a);
			r[s] = r[7];
			r[7] = d;
		end
		if (c == 5) begin
			r[7] = a;
			v = rd(r[6], 1'b0);
			chk("ret", v, result_q);
			r[s] = v;
			r[6] = r[6] + 16'h2;
		end
		chk("err", {15'h0, f}, {15'h0, err_q});
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		logic [31:0] x;
		logic [2:0]  s;
		int          c;
		resetn = 1'b0;
		op_valid = 1'b0;
		op_in = '0;
		r = '{default: 16'h0000};
		repeat (6) @(posedge core_clk);
		#1 resetn = 1'b1;
		@(posedge core_clk);
		#1;
		for (int i = 0; i < 8; i++) op(1, i[2:0], 1'b0, 16'h0);
		op(0, 3'h6, 1'b0, 16'h1001);
		op(0, 3'h3, 1'b0, 16'h0801);
		op(2, 3'h3, 1'b1, 16'h00a5);
		op(2, 3'h6, 1'b1, 16'h1234);
		op(3, 3'h6, 1'b1, 16'h0);
		op(3, 3'h3, 1'b1, 16'h0);
		op(2, 3'h7, 1'b0, 16'h1111);
		op(3, 3'h7, 1'b0, 16'h0);
		op(4, 3'h7, 1'b0, 16'h0300);
		op(4, 3'h5, 1'b0, 16'h0400);
		op(5, 3'h5, 1'b0, 16'h0);
		op(5, 3'h7, 1'b0, 16'h0);
		repeat (300) begin
			x = xs();
			c = x % 6;
			s = x[5:3];
			if (c > 3 && s == 3'h6) s = 3'h5;
			op(c, s, c inside {2, 3} && x[6], x[31:16]);
		end
		for (int i = 0; i < 8; i++) op(1, i[2:0], 1'b0, 16'h0);
		finish_test();
	end
endmodule // tb_stack_linkage_unit
bind stack_linkage_unit stack_link_assertions chk_i (
	.core_clk    (core_clk),
	.resetn      (resetn),
	.op_valid    (op_valid),
	.op_in       (op_in),
	.op_ready_q  (op_ready_q),
	.done_q      (done_q),
	.err_q       (err_q),
	.result_q    (result_q),
	.mem_valid_q (mem_valid_q),
	.mem_cmd_q   (mem_cmd_q),
	.mem_ack     (mem_ack)
);
`default_nettype wire
